//--- shared/pfs_consts.vh
// Behaviour
// - Overload lasting over 112 ms total stops switching 2.5 s, then restarts.
// - Overload counted from a sag below startup threshold near 360 V until link reaches nominal.
// - Gate drive off when digitized output falls below digitized line value.
// - After sense fault, resume only if feedback >= line and link > line peak.
// - Output sense resistor failure detected within about 150 us.
// - Thermal flag above 135 C shuts down, restored after 9 C drop.
// - Low standby request stops switching and enters low-power state.
// - Gate switching frequency never exceeds 70 kHz.
// - Power calculations assume 100 percent boost efficiency.
`ifndef PFS_CONSTS_VH
`define PFS_CONSTS_VH
`define PFS_CLK_HZ 40000000
// Overload accumulation limit and shutdown time
`define PFS_OVL_MS 112
`define PFS_OFF_MS 2500
// 112 ms and 2500 ms at 40 MHz, sized to the counter width
`define PFS_OVL_CYC 27'h0445C00
`define PFS_OFF_CYC 27'h5F5E100
// Overload decay: accumulated time clears at once after a quiet window
`define PFS_QUIET_MS 200
`define PFS_QUIET_CYC 27'h07A1200
// Longest sense-fault detection time, rounded down
`define PFS_DET_US 150
`define PFS_DET_CYC 13'h1770
// Least gate period at 70 kHz, rounded up
`define PFS_FMAX_HZ 70000
`define PFS_MIN_PER_CYC 10'h23C
`define PFS_ADC_W 10
`define PFS_CNT_W 27
`endif

//--- test/pfs_fault_supervisor_tb.sv
`timescale 1ns/1ps
module pfs_fault_supervisor_tb;
    logic core_clk = 1'h0, rst = 1'h1, hot = 1'h0, wish = 1'h0, pull = 1'h0;
    logic [9:0] fb = 10'h1C2, line = 10'h064;
    wire sv, low_power_request_n_n, ovl, lp, gate;
    int err_total = 0, checks_done = 0;
    // 40 MHz clock
    initial forever #12.5 core_clk = ~core_clk;
    pfs_stage_model u_stage (.core_clk(core_clk), .rst(rst), .pull_low(pull), .sample_valid(sv), .low_power_request_n_n(low_power_request_n_n));
    pfs_fault_supervisor #(.OVL_CYC(27'h064), .OFF_CYC(27'h1F4)) u_dut (.core_clk(core_clk),
        .rst(rst), .sample_valid(sv), .output_feedback_current(fb), .line_sense_current(line), .over_temp(hot),
        .startup_threshold(10'h12C), .nominal_threshold(10'h190), .low_power_request_n(low_power_request_n_n),
        .pwm_request(wish), .overload_guard(ovl), .low_power(lp), .switch_gate_drive(gate));
    // Bounded wait, then compare
    task gate_is(input logic v, input int n);
        for (int i = 0; i < n && gate !== v; i++) @(negedge core_clk);
        checks_done++;
        err_total += int'(gate !== v);
        if (gate !== v) $display("[ERR] %0t gate", $time);
    endtask
    // Compare a flag output
    task flag_is(input logic f, input logic v);
        checks_done++;
        err_total += int'(f !== v);
        if (f !== v) $display("[ERR] %0t flag", $time);
    endtask
    // Mid-run reset, then gate returns
    task t_rst;
        rst = 1'h1;
        repeat (2) @(negedge core_clk);
        gate_is(1'h0, 0);
        flag_is(ovl, 1'h0);
        rst = 1'h0;
        gate_is(1'h1, 8);
    endtask
    // Overload trip and restart
    task t_ovl;
        wish = 1'h1;
        gate_is(1'h1, 8);
        fb = 10'h0C8;
        repeat (60) @(negedge core_clk);
        flag_is(ovl, 1'h1);
        gate_is(1'h1, 0);
        gate_is(1'h0, 80);
        fb = 10'h1C2;
        repeat (450) @(negedge core_clk);
        gate_is(1'h0, 0);
        gate_is(1'h1, 150);
    endtask
    // Heat, then standby
    task t_cut;
        hot = 1'h1;
        gate_is(1'h0, 2);
        pull = 1'h1;
        hot = 1'h0;
        repeat (650) @(negedge core_clk);
        gate_is(1'h0, 0);
        flag_is(lp, 1'h1);
        pull = 1'h0;
        @(negedge core_clk);
        flag_is(lp, 1'h0);
        gate_is(1'h1, 700);
    endtask
    // Sense fault, peak-gated recovery
    task t_sense;
        line = 10'h1F4;
        gate_is(1'h0, 12);
        line = 10'h064;
        repeat (600) @(negedge core_clk);
        gate_is(1'h0, 0);
        fb = 10'h258;
        gate_is(1'h1, 700);
    endtask
    task results;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Reset, then scenarios
    initial begin
        repeat (5) @(negedge core_clk);
        rst = 1'h0;
        t_ovl;
        t_cut;
        t_sense;
        t_rst;
        results;
    end
    // Hang guard
    initial begin
        repeat (10000) @(negedge core_clk);
        err_total++;
        results;
    end
endmodule

//--- test/pfs_stage_model.sv
`timescale 1ns/1ps
module pfs_stage_model (
    input wire core_clk,
    input wire rst,
    input wire pull_low,
    output wire sample_valid,
    output wire low_power_request_n_n
);
    reg [1:0] pace_reg;
    // Strobe one cycle in four; standby pulled low only, pull-up releases
    assign sample_valid = &pace_reg;
    assign low_power_request_n_n = pull_low ? 1'h0 : 1'h1;
    // Pacing off the sampling edge
    always @(negedge core_clk or posedge rst) begin
        if (rst) pace_reg <= 2'h0;
        else pace_reg <= pace_reg + 2'h1;
    end
endmodule

//--- test/pfs_sup_properties.sv
`timescale 1ns/1ps
module pfs_sup_properties (
    input wire core_clk, rst, sample_valid, over_temp, low_power_request_n,
    input wire pwm_request, overload_guard, low_power, switch_gate_drive,
    input wire [9:0] output_feedback_current, line_sense_current, startup_threshold
);
    reg [10:0] gap_reg;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Cycles since last gate rise
    always @(posedge core_clk or posedge rst) begin
        if (rst) gap_reg <= 11'h7FF;
        else gap_reg <= $rose(switch_gate_drive) ? 11'h001 : gap_reg + {10'h000, ~&gap_reg};
    end
    AST_LP: assert property (low_power == !low_power_request_n) else $error("lp flag");
    AST_LOW_POWER_REQUEST_N: assert property (!low_power_request_n |=> !switch_gate_drive) else $error("low_power_request_n gate");
    AST_HOT: assert property (over_temp |=> !switch_gate_drive) else $error("hot gate");
    AST_WISH: assert property (!pwm_request |=> !switch_gate_drive) else $error("unasked gate");
    AST_GAP: assert property ($rose(switch_gate_drive) |-> gap_reg >= 11'h23C) else $error("fast gate");
    AST_CAUSE: assert property ($rose(switch_gate_drive) |->
        $past(pwm_request) && $past(low_power_request_n) && !$past(over_temp)) else $error("gate cause");
    AST_SENSE: assert property (sample_valid && output_feedback_current < line_sense_current
        |-> ##2 !switch_gate_drive) else $error("sense trip");
    AST_OVL: assert property (sample_valid && output_feedback_current < startup_threshold
        && !overload_guard && switch_gate_drive |=> overload_guard) else $error("overload");
endmodule
bind pfs_fault_supervisor pfs_sup_properties u_props (.*);

//--- verilog/pfs_fault_supervisor.v
`timescale 1ns/1ps
`include "pfs_consts.vh"
module pfs_fault_supervisor #(
    parameter [`PFS_CNT_W-1:0] OVL_CYC = `PFS_OVL_CYC,
    parameter [`PFS_CNT_W-1:0] OFF_CYC = `PFS_OFF_CYC,
    parameter [`PFS_CNT_W-1:0] QUIET_CYC = `PFS_QUIET_CYC
) (
    input wire core_clk,
    input wire rst,
    input wire sample_valid,
    input wire [`PFS_ADC_W-1:0] output_feedback_current,
    input wire [`PFS_ADC_W-1:0] line_sense_current,
    input wire [`PFS_ADC_W-1:0] startup_threshold,
    input wire [`PFS_ADC_W-1:0] nominal_threshold,
    input wire over_temp,
    input wire low_power_request_n,
    input wire pwm_request,
    output wire overload_guard,
    output wire low_power,
    output reg switch_gate_drive
);
    //--------------------------------------------------------------
    // State encodings
    //--------------------------------------------------------------
    localparam [2:0] ST_RUN = 3'b001;
    localparam [2:0] ST_OFF = 3'b010;
    localparam [2:0] ST_RESTART = 3'b100;
    localparam [12:0] DET_CYC = `PFS_DET_CYC;
    localparam [9:0] MIN_PER = `PFS_MIN_PER_CYC;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [`PFS_CNT_W-1:0] ovl_reg;
    reg [`PFS_CNT_W-1:0] quiet_reg;
    reg [`PFS_CNT_W-1:0] off_reg;
    reg startup_mode_reg;
    reg sense_fault_reg;
    reg [12:0] det_reg;
    reg [9:0] per_reg;
    wire [`PFS_ADC_W-1:0] peak_line;

    // Compare helper used by several checks
    function below;
        input [`PFS_ADC_W-1:0] a;
        input [`PFS_ADC_W-1:0] b;
        begin
            below = (a < b);
        end
    endfunction

    //--------------------------------------------------------------
    // Peak rectified line tracker
    //--------------------------------------------------------------
    pfs_peak_hold u_peak (
        .core_clk(core_clk),
        .rst(rst),
        .sample_valid(sample_valid),
        .sample(line_sense_current),
        .peak_reg(peak_line)
    );

    //--------------------------------------------------------------
    // Overload detection and startup mode
    //--------------------------------------------------------------
    // Sag below startup threshold enters startup mode until nominal
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            startup_mode_reg <= 1'b0;
        end else if (sample_valid) begin
            if (below(output_feedback_current, startup_threshold))
                startup_mode_reg <= 1'b1;
            else if (!below(output_feedback_current, nominal_threshold))
                startup_mode_reg <= 1'b0;
        end
    end
    assign overload_guard = startup_mode_reg;

    // Accumulate overload time; repeated events add up until a quiet gap
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ovl_reg <= {`PFS_CNT_W{1'b0}};
            quiet_reg <= {`PFS_CNT_W{1'b0}};
        end else if (state_reg != ST_RUN) begin
            ovl_reg <= {`PFS_CNT_W{1'b0}};
            quiet_reg <= {`PFS_CNT_W{1'b0}};
        end else if (startup_mode_reg) begin
            ovl_reg <= ovl_reg + {{(`PFS_CNT_W-1){1'b0}}, 1'b1};
            quiet_reg <= {`PFS_CNT_W{1'b0}};
        end else if (quiet_reg >= QUIET_CYC) begin
            ovl_reg <= {`PFS_CNT_W{1'b0}};
        end else begin
            quiet_reg <= quiet_reg + {{(`PFS_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    //--------------------------------------------------------------
    // Shutdown and restart sequencer
    //--------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (ovl_reg >= OVL_CYC)
                    state_next = ST_OFF;
            end
            ST_OFF: begin
                if (off_reg >= OFF_CYC - {{(`PFS_CNT_W-1){1'b0}}, 1'b1})
                    state_next = ST_RESTART;
            end
            ST_RESTART: begin
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    // State register and shutdown timer
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_RUN;
            off_reg <= {`PFS_CNT_W{1'b0}};
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_OFF)
                off_reg <= off_reg + {{(`PFS_CNT_W-1){1'b0}}, 1'b1};
            else
                off_reg <= {`PFS_CNT_W{1'b0}};
        end
    end

    //--------------------------------------------------------------
    // Open/short sense path check
    //--------------------------------------------------------------
    // Trip immediately on output below line; clear with hysteresis
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sense_fault_reg <= 1'b0;
        end else if (sample_valid) begin
            if (below(output_feedback_current, line_sense_current))
                sense_fault_reg <= 1'b1;
            else if (!below(output_feedback_current, line_sense_current) &&
                     !below(output_feedback_current, peak_line) &&
                     (output_feedback_current != peak_line))
                sense_fault_reg <= 1'b0;
        end
    end

    // Watchdog: samples missing for the detection window also count as fault
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            det_reg <= 13'h0000;
        else if (sample_valid)
            det_reg <= 13'h0000;
        else if (det_reg != DET_CYC)
            det_reg <= det_reg + 13'h0001;
    end

    //--------------------------------------------------------------
    // Gate drive: enable AND, with minimum period
    //--------------------------------------------------------------
    assign low_power = ~low_power_request_n;

    wire gate_enable = (state_reg == ST_RUN) && !sense_fault_reg && (det_reg != DET_CYC) &&
                       !over_temp && low_power_request_n;

    // No efficiency derating: gate timing treats the stage as lossless
    // New turn-on allowed only after minimum period elapsed
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            per_reg <= 10'h000;
            switch_gate_drive <= 1'b0;
        end else begin
            if (per_reg != 10'h000)
                per_reg <= per_reg - 10'h001;
            if (!gate_enable) begin
                switch_gate_drive <= 1'b0;
            end else if (pwm_request && !switch_gate_drive && per_reg == 10'h000) begin
                switch_gate_drive <= 1'b1;
                per_reg <= MIN_PER - 10'h001;
            end else if (!pwm_request) begin
                switch_gate_drive <= 1'b0;
            end
        end
    end
endmodule

//--- verilog/pfs_peak_hold.v
`timescale 1ns/1ps
`include "pfs_consts.vh"
// Holds the peak of the line sample, decays slowly so it follows the line
module pfs_peak_hold (
    input wire core_clk,
    input wire rst,
    input wire sample_valid,
    input wire [`PFS_ADC_W-1:0] sample,
    output reg [`PFS_ADC_W-1:0] peak_reg
);
    reg [11:0] decay_reg;
    // Capture new peak, else leak one code every 4096 samples
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            peak_reg <= {`PFS_ADC_W{1'b0}};
            decay_reg <= 12'h000;
        end else if (sample_valid) begin
            decay_reg <= decay_reg + 12'h001;
            if (sample > peak_reg)
                peak_reg <= sample;
            else if (decay_reg == 12'hFFF && peak_reg != {`PFS_ADC_W{1'b0}})
                peak_reg <= peak_reg - {{(`PFS_ADC_W-1){1'b0}}, 1'b1};
        end
    end
endmodule
